// ===== rtl/pdc_pkg.sv
// Purpose: shared constants and types of the program/debug instruction controller
// Assumes: byte-level physical layer outside this block
// Notes: opcode layout is a local encoding, see instruction struct
package pdc_pkg;
    localparam int PDC_DW = 8;
    localparam int PDC_AW = 32;
    localparam int PDC_FIFO_DEPTH = 16;

    // instruction byte: op | spare | address size or pointer mode | data size
    typedef struct packed {
        logic [2:0] op;
        logic spare;
        logic [1:0] asz;
        logic [1:0] dsz;
    } pdc_instr_t;

    localparam logic [2:0] PDC_OP_LDS = 3'h0;
    localparam logic [2:0] PDC_OP_LD = 3'h1;
    localparam logic [2:0] PDC_OP_STS = 3'h2;
    localparam logic [2:0] PDC_OP_ST = 3'h3;
    localparam logic [2:0] PDC_OP_CTRL_SPACE_LOAD_INSTR = 3'h4;
    localparam logic [2:0] PDC_OP_RPT = 3'h5;
    localparam logic [2:0] PDC_OP_CTRL_SPACE_STORE_INSTR = 3'h6;
    localparam logic [2:0] PDC_OP_KEY = 3'h7;

    // pointer modes of the indirect instructions
    localparam logic [1:0] PDC_PTR_IND = 2'h0;
    localparam logic [1:0] PDC_PTR_INC = 2'h1;
    localparam logic [1:0] PDC_PTR_REG = 2'h2;

    localparam logic [63:0] PDC_UNLOCK_KEY = 64'h1289AB45CDD888FF;
    localparam logic [2:0] PDC_KEY_LAST = 3'h7;
    localparam int PDC_KEY_LSB = 8;

    localparam logic [1:0] PDC_CSR_STATUS = 2'h0;
    localparam logic [1:0] PDC_CSR_RESET = 2'h1;
    localparam logic [1:0] PDC_CSR_CTRL = 2'h2;
    localparam int PDC_NVMEN_BIT = 1;
    localparam logic [7:0] PDC_RESET_SIG = 8'h59;
    localparam logic [7:0] PDC_RESET_INIT = 8'h00;
    localparam logic [2:0] PDC_GUARD_INIT = 3'h0;

    // one received character from the physical layer
    typedef struct packed {
        logic strobe;
        logic brk;
        logic frm;
        logic par;
        logic [7:0] data;
    } pdc_rx_t;

    typedef enum logic [2:0] {
        PDC_S_IDLE,
        PDC_S_ADDR,
        PDC_S_OPND,
        PDC_S_WDATA,
        PDC_S_WBUS,
        PDC_S_RBUS,
        PDC_S_PUSH,
        PDC_S_ERR
    } pdc_state_t;
endpackage

// ===== rtl/pdc_ctrl.sv
// Purpose: byte-level program/debug port controller with response FIFO
// Assumes: link clock sampled by core_clk_in, at least 4 core cycles per half period
// Notes: physical framing, guard time and collision sensing live in the physical layer
`timescale 1ns/1ns

module pdc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_r;
    logic [PW-1:0] rd_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_out = cnt_r != (PW+1)'(DEPTH);
    assign out_valid_out = cnt_r != '0;
    assign out_data_out = mem[rd_r];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem[wr_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in || flush_in)
        begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wr_r <= push ? wr_r + 1'b1 : wr_r;
            rd_r <= pop ? rd_r + 1'b1 : rd_r;
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

module pdc_ctrl
    import pdc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic link_clk_in,
    input wire pdc_rx_t rx_in,
    input wire logic collision_in,
    input wire logic tx_ready_in,
    output logic tx_valid_out,
    output logic [7:0] tx_data_out,
    output logic tx_mode_out,
    output logic [2:0] guard_time_out,
    output logic [31:0] bus_addr_out,
    output logic [7:0] bus_wdata_out,
    output logic bus_we_out,
    output logic bus_re_out,
    input wire logic [7:0] bus_rdata_in,
    input wire logic bus_ack_in,
    input wire logic nvm_ctrl_en_in,
    input wire logic other_rst_in,
    output logic dev_rst_out,
    output logic nvm_en_out,
    output logic error_out
);
    logic [2:0] lclk_r;
    pdc_rx_t rx_s1_r;
    pdc_rx_t rx_s2_r;
    logic [1:0] coll_r;
    logic [1:0] txrdy_r;
    pdc_state_t state_r;
    pdc_instr_t instr_r;
    logic [31:0] ptr_r;
    logic [31:0] addr_r;
    logic [31:0] rpt_r;
    logic [63:0] key_r;
    logic [2:0] idx_r;
    logic [7:0] data_r;
    logic wait_r;
    logic nvm_en_r;
    logic [7:0] rst_sig_r;
    logic [2:0] guard_r;
    logic tx_mode_r;
    logic tx_valid_r;
    logic [7:0] tx_data_r;
    logic bus_re_r;
    logic bus_we_r;
    logic dev_rst_r;
    logic brk_exc_r;
    logic link_rise;
    logic rx_fire;
    logic brk_seen;
    logic exc;
    logic allowed;
    logic adv;
    logic fin;
    logic inc;
    logic ptr_mode;
    logic [2:0] lim;
    logic [63:0] key_nxt;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;

    function automatic logic [31:0] set_byte(input logic [31:0] v, input logic [1:0] i,
                                             input logic [7:0] b);
        logic [31:0] r;
        r = v;
        r[i*8 +: 8] = b;
        return r;
    endfunction

    // first state of an instruction, also used to restart it on repetition
    function automatic pdc_state_t launch(input pdc_instr_t ins);
        pdc_state_t s;
        s = PDC_S_IDLE;
        case (ins.op)
            PDC_OP_LDS, PDC_OP_STS: s = PDC_S_ADDR;
            PDC_OP_LD, PDC_OP_CTRL_SPACE_LOAD_INSTR: s = PDC_S_RBUS;
            PDC_OP_ST, PDC_OP_CTRL_SPACE_STORE_INSTR: s = PDC_S_WDATA;
            default: s = PDC_S_OPND;
        endcase
        return s;
    endfunction

    // link clock through three flops (two to sync, one for the edge), other link-domain inputs through two
    always_ff @(posedge core_clk_in)
    begin
        lclk_r <= {lclk_r[1:0], link_clk_in};
        rx_s1_r <= rx_in;
        rx_s2_r <= rx_s1_r;
        coll_r <= {coll_r[0], collision_in};
        txrdy_r <= {txrdy_r[0], tx_ready_in};
    end

    always_comb
    begin
        link_rise = lclk_r[1] && !lclk_r[2];
        brk_seen = link_rise && rx_s2_r.strobe && rx_s2_r.brk;
        rx_fire = link_rise && rx_s2_r.strobe && !rx_s2_r.par && !rx_s2_r.frm && !tx_mode_r;
        exc = state_r != PDC_S_ERR && link_rise && (
              (rx_s2_r.strobe && (rx_s2_r.par || rx_s2_r.frm) && !tx_mode_r) ||
              (coll_r[1] && tx_mode_r));
        allowed = nvm_en_r && nvm_ctrl_en_in;
        ptr_mode = instr_r.asz == PDC_PTR_REG;
        inc = (instr_r.op == PDC_OP_LD || instr_r.op == PDC_OP_ST)
              && instr_r.asz == PDC_PTR_INC;
        lim = (instr_r.op == PDC_OP_CTRL_SPACE_LOAD_INSTR || instr_r.op == PDC_OP_CTRL_SPACE_STORE_INSTR) ? 3'h0
              : {1'b0, instr_r.dsz};
        adv = !exc && ((state_r == PDC_S_WDATA && rx_fire && (instr_r.op == PDC_OP_CTRL_SPACE_STORE_INSTR
              || (instr_r.op == PDC_OP_ST && ptr_mode) || !allowed))
              || (state_r == PDC_S_WBUS && bus_ack_in)
              || (state_r == PDC_S_PUSH && fifo_in_ready));
        fin = adv && idx_r == lim;
        key_nxt = {rx_s2_r.data, key_r[63:PDC_KEY_LSB]};
    end

    always_ff @(posedge core_clk_in)
    begin
        bus_re_r <= 1'b0;
        bus_we_r <= 1'b0;
        if (rst_in)
        begin
            state_r <= PDC_S_IDLE;
            instr_r <= '0;
            ptr_r <= '0;
            addr_r <= '0;
            rpt_r <= '0;
            key_r <= '0;
            idx_r <= '0;
            data_r <= '0;
            wait_r <= 1'b0;
            nvm_en_r <= 1'b0;
            rst_sig_r <= PDC_RESET_INIT;
            guard_r <= PDC_GUARD_INIT;
        end
        else if (exc)
        begin
            state_r <= PDC_S_ERR;
            wait_r <= 1'b0;
            idx_r <= '0;
        end
        else
        begin
            case (state_r)
                PDC_S_IDLE:
                begin
                    if (rx_fire)
                    begin
                        instr_r <= rx_s2_r.data;
                        state_r <= launch(rx_s2_r.data);
                        addr_r <= ptr_r;
                        idx_r <= '0;
                        key_r <= '0;
                        if (rx_s2_r.data[7:5] == PDC_OP_RPT)
                        begin
                            rpt_r <= '0;
                        end
                    end
                end
                PDC_S_ADDR:
                begin
                    if (rx_fire)
                    begin
                        ptr_r <= set_byte(ptr_r, idx_r[1:0], rx_s2_r.data);
                        if (idx_r[1:0] == instr_r.asz)
                        begin
                            idx_r <= '0;
                            addr_r <= set_byte(ptr_r, idx_r[1:0], rx_s2_r.data);
                            state_r <= instr_r.op == PDC_OP_LDS ? PDC_S_RBUS : PDC_S_WDATA;
                        end
                        else
                        begin
                            idx_r <= idx_r + 3'h1;
                        end
                    end
                end
                PDC_S_OPND:
                begin
                    if (rx_fire)
                    begin
                        idx_r <= idx_r + 3'h1;
                        if (instr_r.op == PDC_OP_KEY)
                        begin
                            key_r <= key_nxt;
                            if (idx_r == PDC_KEY_LAST)
                            begin
                                nvm_en_r <= key_nxt == PDC_UNLOCK_KEY;
                                rpt_r <= '0;
                                state_r <= PDC_S_IDLE;
                            end
                        end
                        else
                        begin
                            rpt_r <= set_byte(rpt_r, idx_r[1:0], rx_s2_r.data);
                            if (idx_r[1:0] == instr_r.dsz)
                            begin
                                state_r <= PDC_S_IDLE;
                            end
                        end
                    end
                end
                PDC_S_WDATA:
                begin
                    if (rx_fire)
                    begin
                        data_r <= rx_s2_r.data;
                        if (instr_r.op == PDC_OP_CTRL_SPACE_STORE_INSTR)
                        begin
                            if (instr_r.dsz == PDC_CSR_STATUS)
                            begin
                                nvm_en_r <= 1'b0;
                            end
                            else if (instr_r.dsz == PDC_CSR_RESET)
                            begin
                                rst_sig_r <= rx_s2_r.data;
                            end
                            else if (instr_r.dsz == PDC_CSR_CTRL)
                            begin
                                guard_r <= rx_s2_r.data[2:0];
                            end
                        end
                        else if (instr_r.op == PDC_OP_ST && ptr_mode)
                        begin
                            ptr_r <= set_byte(ptr_r, idx_r[1:0], rx_s2_r.data);
                        end
                        else if (allowed)
                        begin
                            bus_we_r <= 1'b1;
                            state_r <= PDC_S_WBUS;
                        end
                    end
                end
                PDC_S_RBUS:
                begin
                    if (instr_r.op == PDC_OP_CTRL_SPACE_LOAD_INSTR)
                    begin
                        if (instr_r.dsz == PDC_CSR_STATUS)
                        begin
                            data_r <= 8'(nvm_en_r) << PDC_NVMEN_BIT;
                        end
                        else if (instr_r.dsz == PDC_CSR_RESET)
                        begin
                            data_r <= {7'h00, dev_rst_r};
                        end
                        else if (instr_r.dsz == PDC_CSR_CTRL)
                        begin
                            data_r <= {5'h00, guard_r};
                        end
                        else
                        begin
                            data_r <= 8'h00;
                        end
                        state_r <= PDC_S_PUSH;
                    end
                    else if (instr_r.op == PDC_OP_LD && ptr_mode)
                    begin
                        data_r <= ptr_r[idx_r[1:0]*8 +: 8];
                        state_r <= PDC_S_PUSH;
                    end
                    else if (!wait_r && allowed)
                    begin
                        bus_re_r <= 1'b1;
                        wait_r <= 1'b1;
                    end
                    else if (!wait_r)
                    begin
                        data_r <= 8'h00;
                        state_r <= PDC_S_PUSH;
                    end
                    else if (bus_ack_in)
                    begin
                        data_r <= bus_rdata_in;
                        wait_r <= 1'b0;
                        state_r <= PDC_S_PUSH;
                    end
                end
                PDC_S_ERR:
                begin
                    if (brk_seen || brk_exc_r)
                    begin
                        state_r <= PDC_S_IDLE;
                    end
                end
                default:
                begin
                end
            endcase
            if (fin)
            begin
                idx_r <= '0;
                if (inc)
                begin
                    ptr_r <= addr_r + 32'h1;
                end
                if (rpt_r != '0)
                begin
                    rpt_r <= rpt_r - 32'h1;
                    state_r <= launch(instr_r);
                    addr_r <= inc ? addr_r + 32'h1 : ptr_r;
                end
                else
                begin
                    state_r <= PDC_S_IDLE;
                end
            end
            else if (adv)
            begin
                idx_r <= idx_r + 3'h1;
                addr_r <= addr_r + 32'h1;
                state_r <= (instr_r.op == PDC_OP_LDS || instr_r.op == PDC_OP_LD)
                           ? PDC_S_RBUS : PDC_S_WDATA;
            end
        end
    end

    // device reset from signature or any other source
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            dev_rst_r <= 1'b0;
        end
        else
        begin
            dev_rst_r <= rst_sig_r == PDC_RESET_SIG || other_rst_in;
        end
    end

    // a break that raised the exception also ends it, so one break resyncs from any state in receive mode
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            brk_exc_r <= 1'b0;
        end
        else
        begin
            brk_exc_r <= exc && rx_s2_r.strobe && rx_s2_r.brk && !tx_mode_r;
        end
    end

    pdc_fifo #(
        .WIDTH(PDC_DW),
        .DEPTH(PDC_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .flush_in(exc),
        .in_valid_in(state_r == PDC_S_PUSH),
        .in_ready_out(fifo_in_ready),
        .in_data_in(data_r),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_out_ready),
        .out_data_out(fifo_out_data)
    );

    // output stage, consumed by the physical layer on a link rising edge
    assign fifo_out_ready = !tx_valid_r || (link_rise && txrdy_r[1]);

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in || exc)
        begin
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
            tx_mode_r <= 1'b0;
        end
        else
        begin
            if (fifo_out_ready)
            begin
                tx_valid_r <= fifo_out_valid;
                tx_data_r <= fifo_out_valid ? fifo_out_data : tx_data_r;
            end
            tx_mode_r <= fifo_out_valid || tx_valid_r || state_r == PDC_S_PUSH
                         || (state_r == PDC_S_RBUS && !exc);
        end
    end

    assign tx_valid_out = tx_valid_r;
    assign tx_data_out = tx_data_r;
    assign tx_mode_out = tx_mode_r;
    assign guard_time_out = guard_r;
    assign bus_addr_out = addr_r;
    assign bus_wdata_out = data_r;
    assign bus_we_out = bus_we_r;
    assign bus_re_out = bus_re_r;
    assign dev_rst_out = dev_rst_r;
    assign nvm_en_out = nvm_en_r;
    assign error_out = state_r == PDC_S_ERR;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    key_unlock_a: assert property (
        (state_r == PDC_S_OPND && rx_fire && !exc && instr_r.op == PDC_OP_KEY
         && idx_r == PDC_KEY_LAST) |=> nvm_en_r == ($past(key_nxt) == PDC_UNLOCK_KEY))
        else $error("key check result wrong");
    bus_lock_a: assert property (
        (bus_re_r || bus_we_r) |-> $past(nvm_en_r))
        else $error("bus access while locked");
    nvm_gate_a: assert property (
        (bus_re_r || bus_we_r) |-> $past(nvm_ctrl_en_in))
        else $error("bus access with memory controller off");
    rx_exc_a: assert property (
        (link_rise && rx_s2_r.strobe && rx_s2_r.frm && !tx_mode_r
         && state_r != PDC_S_ERR) |=> state_r == PDC_S_ERR)
        else $error("receive error not taken");
    coll_exc_a: assert property (
        (link_rise && coll_r[1] && tx_mode_r) |=> state_r == PDC_S_ERR && !tx_valid_r)
        else $error("collision not taken");
    err_hold_a: assert property (
        (state_r == PDC_S_ERR && !brk_seen && !brk_exc_r) |=> state_r == PDC_S_ERR)
        else $error("error state left without break");
    err_exit_a: assert property (
        (state_r == PDC_S_ERR && brk_seen) |=> state_r == PDC_S_IDLE)
        else $error("break did not clear error");
    rst_hold_a: assert property (
        (rst_sig_r == PDC_RESET_SIG) [*2] |-> dev_rst_out)
        else $error("reset signature not honoured");
    single_beat_a: assert property (
        (bus_re_r || bus_we_r) |=> !bus_re_r && !bus_we_r)
        else $error("bus strobe longer than one cycle");
    rpt_dec_a: assert property (
        (fin && rpt_r != '0) |=> rpt_r == $past(rpt_r) - 32'h1 && state_r != PDC_S_IDLE)
        else $error("repeat counter not decremented");

    unlock_c: cover property (nvm_en_r && bus_we_r);
    resync_c: cover property (state_r == PDC_S_ERR ##[1:200] state_r == PDC_S_IDLE);
    repeat_c: cover property (fin && rpt_r == 32'h1);
    fifo_full_c: cover property (!fifo_in_ready);
endmodule

// ===== dv/pdc_prog_model.sv
// Purpose: programmer-side model of the link: link clock, received chars, reply handshake
// Assumes: framing done by the phy; link clock stands low between frames
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ns
module pdc_prog_model
    import pdc_pkg::*;
#(
    parameter int READY_DLY = 2
)
(
    output logic link_clk_out,
    output pdc_rx_t rx_out,
    output logic collision_out,
    output logic tx_ready_out,
    input wire logic [7:0] tx_data_in
);
    initial
    begin
        link_clk_out = 1'b0;
        rx_out = '0;
        collision_out = 1'b0;
        tx_ready_out = 1'b0;
    end
    task automatic tick();
        #32 link_clk_out = 1'b1;
        #32 link_clk_out = 1'b0;
    endtask
    // one char per frame; a break is also flagged as frame error
    task automatic send(input logic [7:0] d, input logic brk, input logic bad);
        rx_out = '{1'b1, brk, brk, bad, d};
        tick();
        rx_out = '{1'b0, 1'b0, 1'b0, 1'b0, ~d};
        #128;
    endtask
    // slow taker: idle frames before ready, optional collision while taking
    task automatic recv(output logic [7:0] d, input logic coll);
        repeat (READY_DLY) tick();
        d = tx_data_in;
        tx_ready_out = 1'b1;
        collision_out = coll;
        tick();
        tx_ready_out = 1'b0;
        collision_out = 1'b0;
        #128;
    endtask
endmodule

// ===== dv/tb_top.sv
// Purpose: self-checking bench of the instruction controller
// Assumes: bench acts as internal bus memory with two-cycle ack
// Notes: instruction bytes use the local op/size layout
`timescale 1ns/1ns
module tb_top
    import pdc_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic link_clk, collision, tx_ready, tx_valid, tx_mode, bus_we, bus_re;
    logic bus_ack = 1'b0;
    logic ack_d = 1'b0;
    logic nvm_ctrl_en, other_rst, dev_rst, nvm_en, error;
    logic [7:0] tx_data, bus_wdata;
    logic [7:0] bus_rdata = 8'h00;
    logic [2:0] guard;
    logic [31:0] bus_addr;
    pdc_rx_t rx;
    logic [7:0] mem [0:255];
    int strobes = 0;
    int fail_count = 0;
    int total_checks = 0;
    always #4 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in)
    begin
        ack_d <= bus_we | bus_re;
        bus_ack <= ack_d;
        if (bus_we) mem[bus_addr[7:0]] <= bus_wdata;
        if (bus_re) bus_rdata <= mem[bus_addr[7:0]];
        if (bus_we | bus_re) strobes <= strobes + 1;
    end
    pdc_prog_model #(.READY_DLY(2)) pdc_prog_model_inst (.link_clk_out(link_clk),
        .rx_out(rx), .collision_out(collision), .tx_ready_out(tx_ready), .tx_data_in(tx_data));
    pdc_ctrl pdc_ctrl_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .link_clk_in(link_clk),
        .rx_in(rx), .collision_in(collision), .tx_ready_in(tx_ready), .tx_valid_out(tx_valid),
        .tx_data_out(tx_data), .tx_mode_out(tx_mode), .guard_time_out(guard),
        .bus_addr_out(bus_addr), .bus_wdata_out(bus_wdata), .bus_we_out(bus_we),
        .bus_re_out(bus_re), .bus_rdata_in(bus_rdata), .bus_ack_in(bus_ack),
        .nvm_ctrl_en_in(nvm_ctrl_en), .other_rst_in(other_rst), .dev_rst_out(dev_rst),
        .nvm_en_out(nvm_en), .error_out(error));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_for(ref logic s, input logic v);
        repeat (400)
            if (s !== v) @(posedge core_clk_in);
        if (s !== v)
        begin
            fail_count++;
            $display("Error at %0t: wait timed out", $time);
        end
    endtask
    // keep link edges off core clock edges
    task automatic send_q(input logic [7:0] q[$]);
        @(negedge core_clk_in);
        foreach (q[i]) pdc_prog_model_inst.send(q[i], 1'b0, 1'b0);
    endtask
    task automatic get(output logic [7:0] d, input logic coll);
        wait_for(tx_valid, 1'b1);
        @(negedge core_clk_in);
        pdc_prog_model_inst.recv(d, coll);
        if (!coll && tx_valid !== 1'b1) wait_for(tx_mode, 1'b0);
    endtask
    task automatic t_locked();
        logic [7:0] d;
        send_q('{8'h00, 8'h10});
        get(d, 1'b0);
        check(d, 8'h00);
        check(strobes, 0);
        $display("test locked done");
    endtask
    task automatic t_key();
        logic [7:0] d;
        send_q('{8'hE0});
        for (int i = 0; i < 8; i++) send_q('{PDC_UNLOCK_KEY[8*i+:8]});
        send_q('{8'h80});
        get(d, 1'b0);
        check(d, 8'h02);
        check(nvm_en, 1'b1);
        $display("test key done");
    endtask
    task automatic t_direct();
        logic [7:0] d;
        send_q('{8'h45, 8'h10, 8'h00, 8'hA5, 8'h5A, 8'h05, 8'h10, 8'h00});
        get(d, 1'b0);
        check(d, 8'hA5);
        get(d, 1'b0);
        check(d, 8'h5A);
        check(strobes, 4);
        $display("test direct done");
    endtask
    task automatic t_repeat();
        logic [7:0] d;
        send_q('{8'h6B, 8'h20, 8'h00, 8'h00, 8'h00, 8'hA0, 8'h02, 8'h64});
        send_q('{8'h11, 8'h22, 8'h33, 8'h6B, 8'h20, 8'h00, 8'h00, 8'h00});
        check(strobes, 7);
        send_q('{8'hA0, 8'h11, 8'h24});
        for (int i = 0; i < 18; i++)
        begin
            get(d, 1'b0);
            check(d, i < 3 ? 8'h11 * (i + 1) : 8'(32 + i));
        end
        check({mem[32], mem[33], mem[34]}, 24'h112233);
        $display("test repeat done");
    endtask
    task automatic t_reset();
        logic [7:0] d;
        send_q('{8'hC1, 8'h59});
        check(dev_rst, 1'b1);
        send_q('{8'h81});
        get(d, 1'b0);
        check(d, 8'h01);
        send_q('{8'hC1, 8'h00, 8'hC2, 8'h05});
        check(dev_rst, 1'b0);
        check(guard, 3'h5);
        @(posedge core_clk_in);
        other_rst <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        check(dev_rst, 1'b1);
        other_rst <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        check(dev_rst, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_gate();
        logic [7:0] d;
        @(posedge core_clk_in);
        nvm_ctrl_en <= 1'b0;
        send_q('{8'h00, 8'h10});
        get(d, 1'b0);
        check(d, 8'h00);
        check(strobes, 25);
        @(posedge core_clk_in);
        nvm_ctrl_en <= 1'b1;
        $display("test gate done");
    endtask
    task automatic t_error();
        logic [7:0] d;
        send_q('{8'h00, 8'h10});
        get(d, 1'b1);
        wait_for(error, 1'b1);
        check(error, 1'b1);
        send_q('{8'h80});
        check(error, 1'b1);
        pdc_prog_model_inst.send(8'h00, 1'b1, 1'b0);
        check(error, 1'b0);
        pdc_prog_model_inst.send(8'h80, 1'b0, 1'b1);
        check(error, 1'b1);
        pdc_prog_model_inst.send(8'h00, 1'b1, 1'b0);
        pdc_prog_model_inst.send(8'h00, 1'b1, 1'b0);
        check(error, 1'b0);
        send_q('{8'h80});
        get(d, 1'b0);
        check(d, 8'h02);
        $display("test error done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #150000;
        fail_count++;
        end_of_test();
    end
    initial
    begin
        foreach (mem[i]) mem[i] = 8'(i);
        nvm_ctrl_en = 1'b1;
        other_rst = 1'b0;
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        t_locked();
        t_key();
        t_direct();
        t_repeat();
        t_reset();
        t_gate();
        t_error();
        end_of_test();
    end
endmodule
